// File: hw/bl_pkg.sv
package bl_pkg;
  // ************************************************************
  // serial address and register pointers
  // ************************************************************
  localparam logic [6:0] DEV_ADDR = 7'h38;
  localparam logic [7:0] RA_DIODE = 8'h10;
  localparam logic [7:0] RA_CONFIG = 8'h20;
  localparam logic [7:0] RA_OPTIONS = 8'h30;
  localparam logic [7:0] RA_REG_ON = 8'h50;
  localparam logic [7:0] RA_VCODE = 8'h54;
  localparam logic [7:0] RA_STATUS = 8'h58;
  // field positions
  localparam int CFG_PWM_EN = 0;
  localparam int CFG_PWM_POL = 1;
  localparam int CFG_D5_A = 2;
  localparam int CFG_D6_A = 3;
  localparam int OPT_FSEL_LSB = 6;
  localparam int OPT_FSEL_MSB = 7;
  // values after reset
  localparam logic [5:0] DIODE_RST = 6'h00;
  localparam logic [3:0] CONFIG_RST = 4'hc;
  localparam logic [1:0] FSEL_RST = 2'h0;
  localparam logic [3:0] REG_ON_RST = 4'h0;
  localparam logic [4:0] VCODE_1V80 = 5'h0c;
  localparam logic [4:0] VCODE_2V80 = 5'h18;
  localparam logic [3:0][4:0] VCODE_RST = {VCODE_2V80, VCODE_1V80, VCODE_1V80, VCODE_2V80};
  // ************************************************************
  // timing
  // ************************************************************
  localparam int PCLK_NS = 50;
  localparam int FSEL0_NS = 3000000;
  localparam int FSEL1_NS = 800000;
  localparam int FSEL2_NS = 20000;
  localparam int FSEL3_NS = 1000;
  localparam int FSEL0_CYC = (FSEL0_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int FSEL1_CYC = (FSEL1_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int FSEL2_CYC = (FSEL2_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int FSEL3_CYC = (FSEL3_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int PWM_MIN_NS = 15000;
  localparam int PWM_MIN_CYC = (PWM_MIN_NS + PCLK_NS - 1) / PCLK_NS;
  // host bit phases, 16 pclk per serial bit
  localparam logic [3:0] PH_SET = 4'h2;
  localparam logic [3:0] PH_CTL_HI = 4'h4;
  localparam logic [3:0] PH_HI = 4'h8;
  localparam logic [3:0] PH_CTL_SDA = 4'ha;
  localparam logic [3:0] PH_SMP = 4'hc;
  localparam logic [3:0] PH_LAST = 4'hf;
  // ************************************************************
  // host apb map
  // ************************************************************
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_PWM = 12'h004;
  localparam logic [11:0] A_XFER = 12'h008;
  localparam logic [11:0] A_STATUS = 12'h00c;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int XFER_RD = 16;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_RX = 3'b001, S_ACK = 3'b011,
    S_TX = 3'b010, S_TACK = 3'b110, S_SKIP = 3'b111
  } slv_st_t;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00, M_START = 2'b01, M_BIT = 2'b11, M_STOP = 2'b10
  } mst_st_t;
endpackage

// File: hw/bl_link_if.sv
`timescale 1ns/1ps
interface bl_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic hardware_enable_pin;
  logic pwm_line;
  logic scl;
  logic sda;
  // pulled-up wires resolved from the enables
  assign scl = scl_oe_n | scl_o;
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);
  modport host (output scl_o, scl_oe_n, sda_h_o, sda_h_oe_n, hardware_enable_pin,
    pwm_line, input sda);
  modport dev (input scl, sda, hardware_enable_pin, pwm_line, output sda_d_o, sda_d_oe_n);
endinterface

// File: hw/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;
  sync_state_t r;
  sync_state_t n;
  // first stage feeds only the second
  always_comb begin
    n.s1 = d;
    n.s2 = r.s1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign q = r.s2;
endmodule // sync2

// File: hw/bl_device.sv
`timescale 1ns/1ps
// Functional notes
// - software sets pwm accept and polarity
// - pwm gates group A sinks only
// - host keeps pwm pulses at least 15us while its pwm enable stays set
// - pass mode while headroom suffices
// - headroom low on enabled sink: gain 3/2
// - gain 3/2 held until serial write
// - only enabled sinks are watched
// - gain change filtered, default 3-6ms
// - enable pin low restores defaults
// - host drives enable pin from ctrl[0], high after reset
// - each regulator follows its enable bit
// - regulators off, codes preset after reset
// - 5-bit voltage code per regulator
// - master frames with start and stop
// - repeated start restarts address phase
// - data changes only while clock low
// - answer address 0111000 plus direction bit
// - register byte then data byte
// - msb first, ack on ninth clock
// - pwm enable and polarity reset zero
// - two-bit filter select, four delays
module bl_device
  import bl_pkg::*;
#(
  parameter int FILT_SLOW_CYC = FSEL0_CYC,
  parameter int FILT_MID_CYC = FSEL1_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  bl_link_if.dev link,
  input wire logic [5:0] headroom_low,
  output logic [5:0] led_sink_pins,
  output logic pump_gain_high,
  output logic regulator1_on,
  output logic regulator2_on,
  output logic regulator3_on,
  output logic regulator4_on,
  output logic [3:0][4:0] regulator_voltage_code,
  output logic device_enabled
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    slv_st_t st;
    logic [3:0] cnt;
    logic [1:0] idx;
    logic rw;
    logic nack;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic sda_oe_n;
    logic scl_d;
    logic sda_d;
    logic [5:0] diode;
    logic [3:0] cfg;
    logic [1:0] fsel;
    logic [3:0] reg_on;
    logic [3:0][4:0] vcode;
    logic gain;
    logic [15:0] filt;
    logic [5:0] led;
    logic [3:0] reg_out;
    logic en;
  } dev_state_t;

  localparam dev_state_t DEV_RST = '{st: S_IDLE, cnt: 4'h0, idx: 2'h0, rw: 1'b0,
    nack: 1'b0, sh: 8'h00, ptr: 8'h00, sda_oe_n: 1'b1, scl_d: 1'b1, sda_d: 1'b1,
    diode: DIODE_RST, cfg: CONFIG_RST, fsel: FSEL_RST, reg_on: REG_ON_RST,
    vcode: VCODE_RST, gain: 1'b0, filt: 16'h0000, led: 6'h00, reg_out: 4'h0,
    en: 1'b0};

  dev_state_t r;
  dev_state_t n;
  logic [9:0] in_s;
  logic scl_s, sda_s, hw_s, pwm_s;
  logic [5:0] head_s;
  logic rise, fall, start, stop, wr, watch, accept;
  logic [7:0] rd, rd_nx;
  logic [15:0] lim;
  logic [5:0] grp_a;

  // every pin input crosses two flops before use
  sync2 #(.W(10)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({link.scl, link.sda, link.hardware_enable_pin, link.pwm_line, headroom_low}),
    .q(in_s)
  );
  assign {scl_s, sda_s, hw_s, pwm_s, head_s} = in_s;

  // register read mux, shared by first and follow-on read bytes
  function automatic logic [7:0] rd_byte(input dev_state_t s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == RA_DIODE) v = {2'b00, s.diode};
    else if (a == RA_CONFIG) v = {4'h0, s.cfg};
    else if (a == RA_OPTIONS) v = {s.fsel, 6'h00};
    else if (a == RA_REG_ON) v = {4'h0, s.reg_on};
    else if (a == RA_STATUS) v = {7'h00, s.gain};
    else if (a[7:2] == RA_VCODE[7:2]) v = {3'b000, s.vcode[a[1:0]]};
    return v;
  endfunction

  // ************************************************************
  // bus conditions
  // ************************************************************
  assign rise = scl_s & ~r.scl_d;
  assign fall = ~scl_s & r.scl_d;
  assign start = scl_s & r.scl_d & r.sda_d & ~sda_s;
  assign stop = scl_s & r.scl_d & ~r.sda_d & sda_s;
  assign rd = rd_byte(r, r.ptr);
  assign rd_nx = rd_byte(r, r.ptr + 8'h01);
  assign watch = |(head_s & r.diode) & r.en;
  assign grp_a = {r.cfg[CFG_D6_A], r.cfg[CFG_D5_A], 4'hf};
  assign accept = ~r.cfg[CFG_PWM_EN] | (pwm_s ^ r.cfg[CFG_PWM_POL]);

  // filter length per select code
  always_comb begin
    case (r.fsel)
      2'b00: lim = 16'(FILT_SLOW_CYC);
      2'b01: lim = 16'(FILT_MID_CYC);
      2'b10: lim = 16'(FSEL2_CYC);
      default: lim = 16'(FSEL3_CYC);
    endcase
  end

  // serial slave, gain selector and outputs; pin edges are acted on
  // a few pclk late, which the 16-pclk host bit easily absorbs
  always_comb begin
    n = r;
    wr = 1'b0;
    n.scl_d = scl_s;
    n.sda_d = sda_s;
    if (start) begin
      n.st = S_RX;
      n.cnt = 4'h0;
      n.idx = 2'h0;
      n.rw = 1'b0;
      n.sda_oe_n = 1'b1;
    end else if (stop) begin
      n.st = S_IDLE;
      n.sda_oe_n = 1'b1;
    end else if (rise) begin
      case (r.st)
        S_RX: begin
          n.sh = {r.sh[6:0], sda_s};
          n.cnt = r.cnt + 4'h1;
        end
        S_TX: begin
          n.sh = {r.sh[6:0], 1'b0};
          n.cnt = r.cnt + 4'h1;
        end
        S_TACK: n.nack = sda_s;
        default: ;
      endcase
    end else if (fall) begin
      case (r.st)
        S_RX: begin
          if (r.cnt == 4'h8) begin
            n.st = S_ACK;
            n.sda_oe_n = 1'b0;
            n.idx = (r.idx == 2'h2) ? 2'h2 : r.idx + 2'h1;
            if (r.idx == 2'h0) begin
              n.rw = r.sh[0];
              if (r.sh[7:1] != DEV_ADDR) begin
                n.st = S_SKIP;
                n.sda_oe_n = 1'b1;
              end
            end else if (r.idx == 2'h1) begin
              n.ptr = r.sh;
            end else begin
              wr = 1'b1;
              n.ptr = r.ptr + 8'h01;
              if (r.ptr == RA_DIODE) n.diode = r.sh[5:0];
              else if (r.ptr == RA_CONFIG) n.cfg = r.sh[3:0];
              else if (r.ptr == RA_OPTIONS) n.fsel = r.sh[OPT_FSEL_MSB:OPT_FSEL_LSB];
              else if (r.ptr == RA_REG_ON) n.reg_on = r.sh[3:0];
              else if (r.ptr[7:2] == RA_VCODE[7:2]) n.vcode[r.ptr[1:0]] = r.sh[4:0];
            end
          end
        end
        S_ACK: begin
          n.cnt = 4'h0;
          n.sda_oe_n = 1'b1;
          n.st = S_RX;
          if (r.rw) begin
            n.st = S_TX;
            n.sh = rd;
            n.sda_oe_n = rd[7];
          end
        end
        S_TX: begin
          if (r.cnt == 4'h8) begin
            n.st = S_TACK;
            n.sda_oe_n = 1'b1;
          end else begin
            n.sda_oe_n = r.sh[7];
          end
        end
        S_TACK: begin
          if (r.nack) begin
            n.st = S_SKIP; // master ends the read
          end else begin
            n.st = S_TX;
            n.cnt = 4'h0;
            n.ptr = r.ptr + 8'h01;
            n.sh = rd_nx;
            n.sda_oe_n = rd_nx[7];
          end
        end
        default: ;
      endcase
    end

    // a write drops back to pass mode; a filter expiry in the same
    // cycle still wins, so a real headroom loss is not missed
    if (wr) begin
      n.gain = 1'b0;
      n.filt = 16'h0000;
    end
    if (!r.gain) begin
      if (watch) begin
        n.filt = r.filt + 16'h0001;
        if (r.filt >= lim - 16'h0001) begin
          n.gain = 1'b1;
          n.filt = 16'h0000;
        end
      end else if (!wr) begin
        n.filt = 16'h0000;
      end
    end

    // registered outputs
    n.led = r.diode & ~(grp_a & {6{~accept}}) & {6{hw_s}};
    n.reg_out = r.reg_on & {4{hw_s}};
    n.en = hw_s;
    if (!hw_s) begin
      n = DEV_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= DEV_RST;
    end else begin
      r <= n;
    end
  end

  assign link.sda_d_o = 1'b0;
  assign link.sda_d_oe_n = r.sda_oe_n;
  assign led_sink_pins = r.led;
  assign pump_gain_high = r.gain;
  assign {regulator4_on, regulator3_on, regulator2_on, regulator1_on} = r.reg_out;
  assign regulator_voltage_code = r.vcode;
  assign device_enabled = r.en;
endmodule // bl_device

// File: hw/bl_host.sv
`timescale 1ns/1ps
module bl_host
  import bl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  bl_link_if.host link
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    mst_st_t st;
    logic [3:0] ph;
    logic [3:0] bitn;
    logic [1:0] idx;
    logic rd;
    logic [7:0] rg;
    logic [7:0] dat;
    logic [8:0] sh;
    logic nack;
    logic [7:0] rdata;
    logic scl_oe_n;
    logic sda_oe_n;
    logic [1:0] ctrl;
    logic [15:0] pwm_hi;
    logic [15:0] pwm_per;
    logic [15:0] pwm_cnt;
    logic pwm;
    logic [31:0] prdata;
  } host_state_t;

  host_state_t r;
  host_state_t n;
  logic sda_s, acc, hit, last;
  logic [31:0] rmux;
  logic [15:0] hi_eff;
  logic [7:0] nxt;

  sync2 #(.W(1)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(link.sda),
    .q(sda_s)
  );

  // byte to send at a given position of the frame
  function automatic logic [7:0] frame_byte(input host_state_t s, input logic [1:0] i);
    logic [7:0] b;
    b = 8'hff;
    if (i == 2'h0) b = {DEV_ADDR, 1'b0};
    else if (i == 2'h1) b = s.rg;
    else if (i == 2'h2) b = s.rd ? {DEV_ADDR, 1'b1} : s.dat;
    return b;
  endfunction

  assign acc = psel & penable;
  assign hit = (paddr == A_CTRL) | (paddr == A_PWM) | (paddr == A_XFER) | (paddr == A_STATUS);
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign hi_eff = (r.pwm_hi < 16'(PWM_MIN_CYC)) ? 16'(PWM_MIN_CYC) : r.pwm_hi;
  assign last = (r.rd && r.idx == 2'h3) || (!r.rd && r.idx == 2'h2);
  assign nxt = frame_byte(r, r.idx + 2'h1);

  // apb read mux
  always_comb begin
    rmux = 32'h0000_0000;
    case (paddr)
      A_CTRL: rmux = {30'h0, r.ctrl};
      A_PWM: rmux = {r.pwm_per, r.pwm_hi};
      A_XFER: rmux = {15'h0, r.rd, r.rg, r.dat};
      A_STATUS: rmux = {16'h0, r.rdata, 6'h0, r.nack, (r.st != M_IDLE)};
      default: rmux = 32'h0000_0000;
    endcase
  end

  // apb slave, pwm source and serial master
  always_comb begin
    n = r;
    if (psel && !penable) n.prdata = rmux;
    if (acc && pwrite && paddr == A_CTRL) n.ctrl = pwdata[1:0];
    if (acc && pwrite && paddr == A_PWM) begin
      n.pwm_hi = pwdata[15:0];
      n.pwm_per = pwdata[31:16];
    end
    // period counter; pulses never shorter than the sink settle time while ctrl[1] stays set
    n.pwm_cnt = (r.pwm_cnt + 16'h0001 >= r.pwm_per) ? 16'h0000 : r.pwm_cnt + 16'h0001;
    n.pwm = r.ctrl[1] & (r.pwm_cnt < hi_eff);
    n.ph = r.ph + 4'h1;
    case (r.st)
      M_IDLE: begin
        n.ph = 4'h0;
        if (acc && pwrite && paddr == A_XFER) begin
          n.st = M_START;
          n.idx = 2'h0;
          n.rd = pwdata[XFER_RD];
          n.rg = pwdata[15:8];
          n.dat = pwdata[7:0];
          n.nack = 1'b0;
        end
      end
      M_START: begin
        // drop scl first on a repeated start so sda rises while low
        if (r.ph == 4'h0 && r.idx != 2'h0) n.scl_oe_n = 1'b0;
        if (r.ph == PH_SET) n.sda_oe_n = 1'b1;
        if (r.ph == PH_CTL_HI) n.scl_oe_n = 1'b1;
        if (r.ph == PH_CTL_SDA) n.sda_oe_n = 1'b0;
        if (r.ph == PH_LAST) begin
          n.st = M_BIT;
          n.bitn = 4'h0;
          n.sh = {frame_byte(r, r.idx), 1'b1};
        end
      end
      M_BIT: begin
        if (r.ph == 4'h0) n.scl_oe_n = 1'b0;
        if (r.ph == PH_SET) n.sda_oe_n = r.sh[8];
        if (r.ph == PH_HI) n.scl_oe_n = 1'b1;
        if (r.ph == PH_SMP) begin
          if (r.bitn == 4'h8 && r.idx != 2'h3 && sda_s) n.nack = 1'b1;
          if (r.bitn != 4'h8 && r.idx == 2'h3) n.rdata = {r.rdata[6:0], sda_s};
        end
        if (r.ph == PH_LAST) begin
          n.sh = {r.sh[7:0], 1'b1};
          n.bitn = r.bitn + 4'h1;
          if (r.bitn == 4'h8) begin
            n.bitn = 4'h0;
            n.idx = r.idx + 2'h1;
            n.sh = {nxt, 1'b1};
            if (n.nack || last) n.st = M_STOP;
            else if (r.rd && r.idx == 2'h1) n.st = M_START;
          end
        end
      end
      M_STOP: begin
        if (r.ph == 4'h0) n.scl_oe_n = 1'b0;
        if (r.ph == PH_SET) n.sda_oe_n = 1'b0;
        if (r.ph == PH_CTL_HI) n.scl_oe_n = 1'b1;
        if (r.ph == PH_CTL_SDA) n.sda_oe_n = 1'b1;
        if (r.ph == PH_LAST) n.st = M_IDLE;
      end
      default: n.st = M_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: M_IDLE, ph: 4'h0, bitn: 4'h0, idx: 2'h0, rd: 1'b0, rg: 8'h00,
        dat: 8'h00, sh: 9'h1ff, nack: 1'b0, rdata: 8'h00, scl_oe_n: 1'b1,
        sda_oe_n: 1'b1, ctrl: CTRL_RST, pwm_hi: 16'h0000, pwm_per: 16'h0000,
        pwm_cnt: 16'h0000, pwm: 1'b0, prdata: 32'h0000_0000};
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign link.scl_o = 1'b0;
  assign link.scl_oe_n = r.scl_oe_n;
  assign link.sda_h_o = 1'b0;
  assign link.sda_h_oe_n = r.sda_oe_n;
  assign link.hardware_enable_pin = r.ctrl[0];
  assign link.pwm_line = r.pwm;
endmodule // bl_host

// File: tb/bl_link_checker.sv
`timescale 1ns/1ps
module bl_link_checker
  import bl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_oe_n,
  input wire logic hardware_enable_pin,
  input wire logic pwm_line
);
  // ********
  // frame tracking seen from the wire
  // ********
  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic busy;
    logic rd_dir;
    logic [5:0] bits;
    logic [9:0] pwm_hi;
  } mon_t;
  mon_t mon_reg;
  mon_t mon_next;
  logic rise;
  logic start;
  logic stop;
  assign rise = scl & ~mon_reg.scl_q;
  assign start = scl & mon_reg.scl_q & mon_reg.sda_q & ~sda;
  assign stop = scl & mon_reg.scl_q & ~mon_reg.sda_q & sda;
  // bit count restarts on every start, repeated ones too
  always_comb begin
    mon_next = mon_reg;
    mon_next.scl_q = scl;
    mon_next.sda_q = sda;
    if (start) begin
      mon_next.busy = 1'b1;
      mon_next.rd_dir = 1'b0;
      mon_next.bits = 6'h00;
    end else if (stop) begin
      mon_next.busy = 1'b0;
    end else if (rise && mon_reg.bits != 6'h3f) begin
      mon_next.bits = mon_reg.bits + 6'h01;
    end
    if (rise && mon_reg.bits == 6'h07) begin
      mon_next.rd_dir = sda;
    end
    if (!pwm_line) begin
      mon_next.pwm_hi = 10'h000;
    end else if (mon_reg.pwm_hi != 10'h3ff) begin
      mon_next.pwm_hi = mon_reg.pwm_hi + 10'h001;
    end
  end
  // lines idle high, so history starts released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_reg <= 20'hc0000;
    end else begin
      mon_reg <= mon_next;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_dev_hold_high;
    scl && mon_reg.scl_q |-> $stable(sda_d_oe_n);
  endproperty
  a_dev_hold_high: assert property (p_dev_hold_high)
    else $error("device data moved while clock high");
  property p_idle_release;
    !mon_reg.busy |-> sda_d_oe_n && scl;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("line held outside a frame");
  property p_addr_ack;
    rise && mon_reg.busy && mon_reg.bits == 6'd8 |-> !sda_d_oe_n;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");
  property p_byte_ack;
    rise && mon_reg.busy && !mon_reg.rd_dir && (mon_reg.bits == 6'd17 || mon_reg.bits == 6'd26)
      |-> !sda_d_oe_n;
  endproperty
  a_byte_ack: assert property (p_byte_ack)
    else $error("written byte not acknowledged");
  property p_rx_free;
    rise && mon_reg.busy && !mon_reg.rd_dir && mon_reg.bits < 6'd27 && mon_reg.bits != 6'd8
      && mon_reg.bits != 6'd17 && mon_reg.bits != 6'd26 |-> sda_d_oe_n;
  endproperty
  a_rx_free: assert property (p_rx_free)
    else $error("device drove data during a received bit");
  property p_enable_low;
    !hardware_enable_pin [*5] |-> sda_d_oe_n;
  endproperty
  a_enable_low: assert property (p_enable_low)
    else $error("device active while disabled");
  property p_pwm_min;
    $fell(pwm_line) |-> mon_reg.pwm_hi >= 10'(PWM_MIN_CYC);
  endproperty
  a_pwm_min: assert property (p_pwm_min)
    else $error("dimming pulse too short");
  property p_restart_free;
    start |=> sda_d_oe_n [*3];
  endproperty
  a_restart_free: assert property (p_restart_free)
    else $error("device drove data after a start");
  c_start: cover property (start);
  c_stop: cover property (stop);
  c_read_ack: cover property (rise && mon_reg.rd_dir && mon_reg.bits == 6'd8 && !sda_d_oe_n);
  c_enable_low: cover property ($fell(hardware_enable_pin));
endmodule // bl_link_checker

// File: tb/test_backlight_ldo_control_logic.sv
`timescale 1ns/1ps
module test_backlight_ldo_control_logic
  import bl_pkg::*;
();
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic e;
  } exp_t;
  logic pclk;
  logic presetn;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic chk_cur;
  logic [5:0] headroom_low;
  logic [5:0] led_sink_pins;
  logic pump_gain_high;
  logic [3:0] reg_on;
  logic [3:0][4:0] regulator_voltage_code;
  logic [3:0][4:0] exp_v;
  logic device_enabled;
  logic [31:0] got;
  logic [3:0] cfg;
  logic [3:0] en_exp;
  logic acc;
  integer seed;
  int n;
  int mismatches;
  int compares;
  int lim[4] = '{200, 100, FSEL2_CYC, FSEL3_CYC};
  exp_t exp_q[$];
  exp_t ent;
  bl_link_if link ();
  bl_host i_bl_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  // short filter counts keep the run brief
  bl_device #(.FILT_SLOW_CYC(200), .FILT_MID_CYC(100)) i_bl_device (.pclk(pclk),
    .presetn(presetn), .link(link), .headroom_low(headroom_low), .led_sink_pins(led_sink_pins),
    .pump_gain_high(pump_gain_high), .regulator1_on(reg_on[0]), .regulator2_on(reg_on[1]),
    .regulator3_on(reg_on[2]), .regulator4_on(reg_on[3]),
    .regulator_voltage_code(regulator_voltage_code), .device_enabled(device_enabled));
  bl_link_checker i_bl_link_checker (.pclk(pclk), .presetn(presetn), .scl(link.scl),
    .sda(link.sda), .sda_d_oe_n(link.sda_d_oe_n),
    .hardware_enable_pin(link.hardware_enable_pin), .pwm_line(link.pwm_line));
  // ********
  // bus tasks and comparison
  // ********
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic gain_is(input logic e);
    cmp("gain", {31'h0, e}, {31'h0, pump_gain_high});
  endtask
  // one access; a checked read leaves its note for the watcher
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic chk, input exp_t e);
    int k;
    k = 0;
    if (chk) exp_q.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    chk_cur <= chk;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge pclk);
    end
    if (k == 50) mismatches++;
    got = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_cur <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, '0);
  endtask
  // start a frame and poll until the host is idle again
  task automatic ser(input logic rd, input logic [7:0] ra, input logic [7:0] wd);
    int k;
    k = 0;
    wr(A_XFER, {15'h0, rd, ra, wd});
    got = 32'h1;
    while (got[0] !== 1'b0 && k < 400) begin
      apb(1'b0, A_STATUS, 32'h0, 1'b0, '0);
      k++;
    end
    if (k == 400) mismatches++;
  endtask
  task automatic dev_rd(input logic [7:0] ra, input logic [7:0] e);
    ser(1'b1, ra, 8'h00);
    apb(1'b0, A_STATUS, 32'h0, 1'b1, exp_t'{{16'h0, e, 8'h0}, 32'h0000ff03, 1'b0});
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watcher retires the oldest note at each checked access
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && chk_cur === 1'b1) begin
      ent = exp_q.pop_front();
      cmp("prdata", ent.d, prdata & ent.m);
      cmp("pslverr", {31'h0, ent.e}, {31'h0, pslverr});
    end
  end
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // hang guard, about five times the expected run
  initial begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    chk_cur = 1'b0;
    headroom_low = 6'h00;
    mismatches = 0;
    compares = 0;
    seed = 32'he687e549;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // defaults, host map and an unmapped host word
    apb(1'b0, A_CTRL, 32'h0, 1'b1, exp_t'{{30'h0, CTRL_RST}, 32'h3, 1'b0});
    apb(1'b0, 12'h010, 32'h0, 1'b1, exp_t'{32'h0, 32'hffffffff, 1'b1});
    gain_is(1'b0);
    cmp("reg_on", {28'h0, REG_ON_RST}, {28'h0, reg_on});
    cmp("vcode", {12'h0, VCODE_RST}, {12'h0, regulator_voltage_code});
    dev_rd(RA_CONFIG, {4'h0, CONFIG_RST});
    dev_rd(RA_OPTIONS, {FSEL_RST, 6'h00});
    for (int k = 0; k < 4; k++) dev_rd(RA_VCODE + k[7:0], {3'h0, VCODE_RST[k]});
    // random regulator codes and enables
    for (int k = 0; k < 4; k++) begin
      exp_v[k] = 5'($random(seed));
      ser(1'b0, RA_VCODE + k[7:0], {3'h0, exp_v[k]});
    end
    en_exp = 4'($random(seed));
    ser(1'b0, RA_REG_ON, {4'h0, en_exp});
    repeat (5) @(posedge pclk);
    cmp("reg_on", {28'h0, en_exp}, {28'h0, reg_on});
    cmp("vcode", {12'h0, exp_v}, {12'h0, regulator_voltage_code});
    dev_rd(RA_REG_ON, {4'h0, en_exp});
    // dimming input over accept, polarity and group mixes
    wr(A_PWM, {16'd800, 16'd400});
    wr(A_CTRL, 32'h3);
    ser(1'b0, RA_DIODE, 8'h3f);
    for (int i = 0; i < 8; i++) begin
      cfg = {i[2], ~i[2], i[1:0]};
      ser(1'b0, RA_CONFIG, {4'h0, cfg});
      for (int p = 0; p < 2; p++) begin
        n = 0;
        while (link.pwm_line !== p[0] && n < 2000) begin
          n++;
          @(posedge pclk);
        end
        if (n == 2000) mismatches++;
        repeat (6) @(posedge pclk);
        acc = !cfg[0] | (link.pwm_line ^ cfg[1]);
        cmp("led", {26'h0, ~{cfg[3:2], 4'hf} | {6{acc}}}, {26'h0, led_sink_pins});
      end
    end
    // gain: disabled sinks ignored, then each filter delay
    ser(1'b0, RA_DIODE, 8'h01);
    headroom_low <= 6'h3e;
    repeat (300) @(posedge pclk);
    gain_is(1'b0);
    for (int g = 0; g < 4; g++) begin
      ser(1'b0, RA_OPTIONS, {g[1:0], 6'h00});
      gain_is(1'b0);
      headroom_low <= 6'h3f;
      repeat (lim[g] - 5) @(posedge pclk);
      gain_is(1'b0);
      repeat (12) @(posedge pclk);
      gain_is(1'b1);
      headroom_low <= 6'h3e;
      repeat (50) @(posedge pclk);
      gain_is(1'b1);
    end
    dev_rd(RA_STATUS, 8'h01);
    ser(1'b0, 8'h7f, 8'ha5);
    gain_is(1'b0);
    dev_rd(8'h7f, 8'h00);
    // enable pin low wipes the device
    wr(A_CTRL, 32'h2);
    repeat (8) @(posedge pclk);
    cmp("enabled", 32'h0, {31'h0, device_enabled});
    cmp("led", 32'h0, {26'h0, led_sink_pins});
    cmp("reg_on", 32'h0, {28'h0, reg_on});
    cmp("vcode", {12'h0, VCODE_RST}, {12'h0, regulator_voltage_code});
    wr(A_CTRL, 32'h3);
    repeat (8) @(posedge pclk);
    dev_rd(RA_DIODE, 8'h00);
    dev_rd(RA_CONFIG, {4'h0, CONFIG_RST});
    report_and_stop();
  end
endmodule // test_backlight_ldo_control_logic
